//--- src/ravg_pkg.sv
// Shared constants for the rolling-average oversampler and its host controller
package ravg_pkg;
    // ************************************************************
    // Configuration word layout
    // ************************************************************
    localparam int        CFG_W         = 10;
    localparam int        AVG_EN_BIT    = 9;
    localparam int        RATIO_HI      = 8;
    localparam int        RATIO_LO      = 6;
    localparam int        RES_BOOST_BIT = 2;
    localparam int        REF_SEL_BIT   = 1;
    localparam logic [9:0] CFG_RESET    = 10'h000;
    localparam logic [2:0] RATIO_OFF    = 3'h0;
    localparam logic [2:0] RATIO_MAX    = 3'h3;

    // ************************************************************
    // Data path sizes
    // ************************************************************
    localparam int SAMPLE_W = 16;
    localparam int RESULT_W = 18;
    localparam int DEPTH    = 8;
    localparam int SUM_W    = 19;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_PERIOD_NS  = 8;
    localparam int CONV_TIME_NS   = 200;
    localparam int CONV_CYCLES    = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CS_LOW_NS      = 40;
    localparam int CS_LOW_CYCLES  = (CS_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETTLE_TIME_NS = 5000;
    localparam int SETTLE_CYCLES  = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ************************************************************
    // Host register map
    // ************************************************************
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_CFG    = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_RES_A  = 8'h0C;
    localparam logic [7:0] REG_RES_B  = 8'h10;
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_SOFT_BIT  = 1;
    localparam int CTRL_HARD_BIT  = 2;
    localparam int ST_BUSY_BIT    = 0;
    localparam int ST_SETTLED_BIT = 1;
    localparam int ST_NEW_BIT     = 2;
    localparam int ST_WIDE_BIT    = 3;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CONV = 2'b01,
        ST_AVG  = 2'b10
    } conv_state_t;
endpackage

//--- src/ravg_link_if.sv
// Link between the oversampling converter logic and its host controller
`timescale 1ns/100ps
`default_nettype none
interface ravg_link_if;
    logic        cs_n;
    logic        cfg_wr;
    logic [9:0]  cfg_data;
    logic        soft_rst;
    logic        hard_rst;
    logic [17:0] res_a;
    logic [17:0] res_b;
    logic        res_valid;
    logic        res_wide;
    logic        busy;

    modport device (input cs_n, cfg_wr, cfg_data, soft_rst, hard_rst,
                    output res_a, res_b, res_valid, res_wide, busy);
    modport host (output cs_n, cfg_wr, cfg_data, soft_rst, hard_rst,
                  input res_a, res_b, res_valid, res_wide, busy);
endinterface
`default_nettype wire

//--- src/ravg_device.sv
// Dual-channel rolling-average oversampler behind a chip-select started converter
// Operation
// RULE1: average only with enable set, nonzero ratio
// RULE2: host clears enable and ratio to stop
// RULE3: conversions start only on chip-select fall
// RULE4: history holds exactly eight results always
// RULE5: first conversion after reset fills all entries
// RULE6: every conversion shifts in, any mode
// RULE7: sum newest n entries, divide by n
// RULE8: plain averaging gives sixteen-bit result
// RULE9: one output result per conversion
// RULE10: averaging never clears stored samples
// RULE11: host chooses chip-select interval
// RULE12: host ignores results before settling
// RULE13: early chip-select activity causes no harm
// RULE14: host sets boost for extra resolution
// RULE15: boost with averaging gives eighteen bits
// RULE16: soft reset flushes history, keeps config
// RULE17: ratio codes pick two, four, eight
`timescale 1ns/100ps
`default_nettype none
module ravg_device (
    input  wire logic        clk_sys,       // System clock
    input  wire logic        rst,           // Async reset, active high
    ravg_link_if.device      link,          // Host side link
    input  wire logic [15:0] sample_a,      // Raw converter code, channel A
    input  wire logic [15:0] sample_b,      // Raw converter code, channel B
    output logic      [9:0]  config_view,   // Current configuration word
    output logic             avg_active     // Averaging mode in force
);
    // ************************************************************
    // Configuration and control state
    // ************************************************************
    logic [9:0]           cfg_q;
    logic                 cs_q;
    logic                 fill_q;
    logic                 push;
    logic                 cs_fall;
    logic                 avg_on;
    logic                 wide_on;
    logic [1:0]           shift_k;
    logic [7:0]           cnt_q;
    ravg_pkg::conv_state_t state_q;
    logic                 busy_q;
    logic                 valid_q;
    logic                 wide_q;
    logic [15:0]          samp [2];

    assign samp[0] = sample_a;
    assign samp[1] = sample_b;

    assign cs_fall = cs_q & ~link.cs_n;
    assign push    = (state_q == ravg_pkg::ST_CONV) && (cnt_q == 8'h00);
    assign avg_on  = cfg_q[ravg_pkg::AVG_EN_BIT]
                     && (cfg_q[ravg_pkg::RATIO_HI:ravg_pkg::RATIO_LO] != ravg_pkg::RATIO_OFF)
                     && (cfg_q[ravg_pkg::RATIO_HI:ravg_pkg::RATIO_LO] <= ravg_pkg::RATIO_MAX); // see RULE1 see RULE17
    assign wide_on = avg_on && cfg_q[ravg_pkg::RES_BOOST_BIT]; // see RULE15
    assign shift_k = cfg_q[ravg_pkg::RATIO_LO+1:ravg_pkg::RATIO_LO]; // see RULE17

    // Configuration survives soft reset, hard reset restores defaults
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cfg_q <= ravg_pkg::CFG_RESET;
        end else if (link.hard_rst) begin
            cfg_q <= ravg_pkg::CFG_RESET;
        end else if (link.cfg_wr) begin
            cfg_q <= link.cfg_data; // see RULE2 see RULE14
        end
    end

    // Chip-select edge history
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cs_q <= 1'b1;
        end else begin
            cs_q <= link.cs_n;
        end
    end

    // Refill request: power-on, soft or hard reset, reference toggle
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            fill_q <= 1'b1;
        end else if (link.soft_rst || link.hard_rst) begin
            fill_q <= 1'b1; // see RULE16
        end else if (link.cfg_wr
                     && (link.cfg_data[ravg_pkg::REF_SEL_BIT] != cfg_q[ravg_pkg::REF_SEL_BIT])) begin
            fill_q <= 1'b1; // see RULE5
        end else if (push) begin
            fill_q <= 1'b0;
        end
    end

    // ************************************************************
    // Conversion sequencer
    // ************************************************************
    // Edges during a conversion are ignored, so early or stray
    // pulses cannot wedge the sequencer.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_q <= ravg_pkg::ST_IDLE;
            cnt_q   <= 8'h00;
            busy_q  <= 1'b0;
        end else if (link.soft_rst || link.hard_rst) begin
            state_q <= ravg_pkg::ST_IDLE; // see RULE16
            cnt_q   <= 8'h00;
            busy_q  <= 1'b0;
        end else begin
            case (state_q)
                ravg_pkg::ST_IDLE: begin
                    if (cs_fall) begin
                        state_q <= ravg_pkg::ST_CONV; // see RULE3 see RULE13
                        cnt_q   <= 8'(ravg_pkg::CONV_CYCLES - 1);
                        busy_q  <= 1'b1;
                    end
                end
                ravg_pkg::ST_CONV: begin
                    if (cnt_q == 8'h00) begin
                        state_q <= ravg_pkg::ST_AVG;
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                ravg_pkg::ST_AVG: begin
                    state_q <= ravg_pkg::ST_IDLE;
                    busy_q  <= 1'b0;
                end
                default: begin
                    state_q <= ravg_pkg::ST_IDLE;
                    busy_q  <= 1'b0;
                end
            endcase
        end
    end

    // One result per conversion
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            valid_q <= 1'b0;
            wide_q  <= 1'b0;
        end else begin
            valid_q <= (state_q == ravg_pkg::ST_AVG) && !link.soft_rst && !link.hard_rst; // see RULE9
            if (state_q == ravg_pkg::ST_AVG) begin
                wide_q <= wide_on;
            end
        end
    end

    // ************************************************************
    // Per-channel history and averaging
    // ************************************************************
    for (genvar ch = 0; ch < 2; ch++) begin : g_ch
        logic [15:0]        hist_q [ravg_pkg::DEPTH];
        logic signed [18:0] sum;
        logic signed [18:0] avg16;
        logic signed [20:0] avg18;
        logic [17:0]        res_d;
        logic [17:0]        res_q;

        // Newest entry at index 0; flush is a refill on the next push
        always_ff @(posedge clk_sys or posedge rst) begin
            if (rst) begin
                for (int i = 0; i < ravg_pkg::DEPTH; i++) begin
                    hist_q[i] <= 16'h0000;
                end
            end else if (push) begin
                hist_q[0] <= samp[ch]; // see RULE6
                for (int i = 1; i < ravg_pkg::DEPTH; i++) begin
                    hist_q[i] <= fill_q ? samp[ch] : hist_q[i-1]; // see RULE4 see RULE5 see RULE10
                end
            end
        end

        // Truncating arithmetic shift, no rounding
        always_comb begin
            sum = 19'sh00000;
            for (int i = 0; i < ravg_pkg::DEPTH; i++) begin
                if (i < (1 << shift_k)) begin
                    sum = sum + $signed({{3{hist_q[i][15]}}, hist_q[i]}); // see RULE7
                end
            end
            avg16 = sum >>> shift_k;
            avg18 = $signed({sum, 2'b00}) >>> shift_k;
            if (!avg_on) begin
                res_d = {{2{hist_q[0][15]}}, hist_q[0]};
            end else if (wide_on) begin
                res_d = avg18[17:0]; // see RULE15
            end else begin
                res_d = {{2{avg16[15]}}, avg16[15:0]}; // see RULE8
            end
        end

        always_ff @(posedge clk_sys or posedge rst) begin
            if (rst) begin
                res_q <= 18'h00000;
            end else if (state_q == ravg_pkg::ST_AVG) begin
                res_q <= res_d;
            end
        end
    end

    // Output flops
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            avg_active <= 1'b0;
        end else begin
            avg_active <= avg_on;
        end
    end

    assign config_view    = cfg_q;
    assign link.res_a     = g_ch[0].res_q;
    assign link.res_b     = g_ch[1].res_q;
    assign link.res_valid = valid_q;
    assign link.res_wide  = wide_q;
    assign link.busy      = busy_q;
endmodule
`default_nettype wire

//--- src/ravg_host.sv
// Host controller: register port in, chip select and configuration out
`timescale 1ns/100ps
`default_nettype none
module ravg_host (
    input  wire logic        clk_sys,   // System clock
    input  wire logic        rst,       // Async reset, active high
    ravg_link_if.host        link,      // Converter side link
    input  wire logic [7:0]  addr,      // Register byte address
    input  wire logic [31:0] wdata,     // Write data
    input  wire logic        wr,        // Write strobe
    input  wire logic        rd,        // Read strobe
    output logic      [31:0] rdata      // Read data, cycle after rd
);
    logic [9:0]  cfg_q;
    logic        cfg_wr_q;
    logic        soft_q;
    logic        hard_q;
    logic        cs_n_q;
    logic [7:0]  cs_cnt_q;
    logic [15:0] settle_q;
    logic        settled_q;
    logic        new_q;
    logic        wide_q;
    logic [17:0] res_a_q;
    logic [17:0] res_b_q;
    logic        wr_ctrl;
    logic        take;

    assign wr_ctrl = wr && (addr == ravg_pkg::REG_CTRL);
    assign take    = link.res_valid && settled_q;

    // ************************************************************
    // Configuration and reset requests
    // ************************************************************
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cfg_q    <= ravg_pkg::CFG_RESET;
            cfg_wr_q <= 1'b0;
            soft_q   <= 1'b0;
            hard_q   <= 1'b0;
        end else begin
            cfg_wr_q <= wr && (addr == ravg_pkg::REG_CFG);
            soft_q   <= wr_ctrl && wdata[ravg_pkg::CTRL_SOFT_BIT];
            hard_q   <= wr_ctrl && wdata[ravg_pkg::CTRL_HARD_BIT];
            if (wr && addr == ravg_pkg::REG_CFG) begin
                cfg_q <= wdata[9:0]; // see RULE2 see RULE14
            end else if (hard_q) begin
                cfg_q <= ravg_pkg::CFG_RESET;
            end
        end
    end

    // Chip-select pulse; a start while busy or low is dropped
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cs_n_q   <= 1'b1;
            cs_cnt_q <= 8'h00;
        end else if (cs_n_q == 1'b0) begin
            if (cs_cnt_q == 8'h00) begin
                cs_n_q <= 1'b1;
            end else begin
                cs_cnt_q <= cs_cnt_q - 8'h01;
            end
        end else if (wr_ctrl && wdata[ravg_pkg::CTRL_START_BIT] && !link.busy) begin
            cs_n_q   <= 1'b0; // see RULE3 see RULE11
            cs_cnt_q <= 8'(ravg_pkg::CS_LOW_CYCLES - 1);
        end
    end

    // Power-up settling; results before it are discarded
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            settle_q  <= 16'h0000;
            settled_q <= 1'b0;
        end else if (!settled_q) begin
            settle_q  <= settle_q + 16'h0001;
            settled_q <= (settle_q == 16'(ravg_pkg::SETTLE_CYCLES - 1)); // see RULE12
        end
    end

    // ************************************************************
    // Result capture and register reads
    // ************************************************************
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            res_a_q <= 18'h00000;
            res_b_q <= 18'h00000;
            wide_q  <= 1'b0;
            new_q   <= 1'b0;
        end else begin
            if (take) begin
                res_a_q <= link.res_a;
                res_b_q <= link.res_b;
                wide_q  <= link.res_wide;
            end
            // New data wins over a clearing read
            if (take) begin
                new_q <= 1'b1;
            end else if (rd && addr == ravg_pkg::REG_RES_A) begin
                new_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rdata <= 32'h00000000;
        end else if (rd) begin
            case (addr)
                ravg_pkg::REG_CFG:    rdata <= {22'h000000, cfg_q};
                ravg_pkg::REG_STATUS: rdata <= {28'h0000000, wide_q, new_q, settled_q, link.busy};
                ravg_pkg::REG_RES_A:  rdata <= {{14{res_a_q[17]}}, res_a_q};
                ravg_pkg::REG_RES_B:  rdata <= {{14{res_b_q[17]}}, res_b_q};
                default:              rdata <= 32'h00000000;
            endcase
        end else begin
            rdata <= 32'h00000000;
        end
    end

    assign link.cs_n     = cs_n_q;
    assign link.cfg_wr   = cfg_wr_q;
    assign link.cfg_data = cfg_q;
    assign link.soft_rst = soft_q;
    assign link.hard_rst = hard_q;
endmodule
`default_nettype wire

//--- dv/ravg_link_assertions.sv
// Concurrent checks on the link between the oversampler and its host
`timescale 1ns/100ps
`default_nettype none
module ravg_link_assertions (
    input wire logic        clk_sys,   // System clock
    input wire logic        rst,       // Async reset
    input wire logic        cs_n,      // Chip select
    input wire logic        cfg_wr,    // Config load
    input wire logic [9:0]  cfg_data,  // Config word
    input wire logic        soft_rst,  // Soft reset pulse
    input wire logic        hard_rst,  // Hard reset pulse
    input wire logic [17:0] res_a,     // Result A
    input wire logic [17:0] res_b,     // Result B
    input wire logic        res_valid, // Result strobe
    input wire logic        res_wide,  // Wide result
    input wire logic        busy       // Conversion running
);
    // ************************************************************
    // Shadow of the device configuration
    // ************************************************************
    logic [9:0] cfg_q;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) cfg_q <= 10'h000;
        else if (hard_rst) cfg_q <= 10'h000;
        else if (cfg_wr) cfg_q <= cfg_data;
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    AST_CS_LOW_LEN: assert property ($fell(cs_n) |-> !cs_n [*5] ##1 cs_n)
        else $error("chip select low time wrong");
    AST_BUSY_FROM_CS: assert property ($rose(busy) |-> !cs_n)
        else $error("conversion began without chip select");
    // A reset pulse aborts the conversion, so it also drops the attempt
    AST_VALID_AFTER_FALL: assert property (disable iff (rst || soft_rst || hard_rst)
        $fell(cs_n) && !busy |-> ##[20:40] res_valid) else $error("no result after start");
    AST_VALID_ENDS_BUSY: assert property (res_valid |-> !busy && $past(busy))
        else $error("result without conversion");
    AST_VALID_PULSE: assert property (res_valid |=> !res_valid)
        else $error("result strobe too long");
    AST_NARROW_SIGNEXT: assert property (res_valid && !res_wide |->
        res_a[17:16] == {2{res_a[15]}} && res_b[17:16] == {2{res_b[15]}}) else $error("narrow result not 16 bit");
    AST_WIDE_MODE: assert property (res_valid |-> res_wide ==
        (cfg_q[9] && cfg_q[8:6] != 3'h0 && cfg_q[8:6] <= 3'h3 && cfg_q[2])) else $error("wide flag wrong");
    AST_RES_STAND: assert property (!res_valid && !$past(soft_rst) && !$past(hard_rst) |->
        $stable(res_a) && $stable(res_b) && $stable(res_wide)) else $error("result changed between strobes");
    AST_ABORT: assert property ((soft_rst || hard_rst) |=> !busy && !res_valid)
        else $error("reset did not abort conversion");
endmodule
`default_nettype wire

//--- dv/tb_rolling_average_oversampler.sv
// Self-checking bench joining the oversampler and its host controller
`timescale 1ns/100ps
`default_nettype none
module tb_rolling_average_oversampler;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [15:0] sample_a = 16'h0000;
    logic [15:0] sample_b = 16'h0000;
    logic [31:0] rdata;
    logic [9:0]  config_view;
    logic        avg_active;
    logic [31:0] seed = 32'h0000_000C;
    logic [15:0] ha [8];
    logic [15:0] hb [8];
    logic [18:0] ea;
    logic [18:0] eb;
    logic [9:0]  cfg_m = 10'h000;
    logic        fill = 1'b1;
    int          n_fail = 0;
    int          comparisons = 0;

    ravg_link_if link ();
    ravg_device i_ravg_device (.clk_sys(clk_sys), .rst(rst), .link(link), .sample_a(sample_a),
        .sample_b(sample_b), .config_view(config_view), .avg_active(avg_active));
    ravg_host i_ravg_host (.clk_sys(clk_sys), .rst(rst), .link(link), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata));
    ravg_link_assertions i_ravg_link_assertions (.clk_sys(clk_sys), .rst(rst), .cs_n(link.cs_n),
        .cfg_wr(link.cfg_wr), .cfg_data(link.cfg_data), .soft_rst(link.soft_rst), .hard_rst(link.hard_rst),
        .res_a(link.res_a), .res_b(link.res_b), .res_valid(link.res_valid), .res_wide(link.res_wide),
        .busy(link.busy));

    always #4 clk_sys = ~clk_sys;

    // ************************************************************
    // Model and bus tasks
    // ************************************************************
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic avg_on(input logic [9:0] c);
        return c[9] && c[8:6] != 3'h0 && c[8:6] <= ravg_pkg::RATIO_MAX;
    endfunction

    // Floor division by shifting, boost keeps two extra fraction bits
    function automatic logic [18:0] exp_out(input logic [15:0] h [8]);
        logic signed [20:0] acc;
        acc = 21'h0;
        if (!avg_on(cfg_m)) return {1'b0, {2{h[0][15]}}, h[0]};
        for (int i = 0; i < (1 << cfg_m[8:6]); i++) acc = acc + 21'(signed'(h[i]));
        if (cfg_m[ravg_pkg::RES_BOOST_BIT]) acc = acc <<< 2;
        acc = acc >>> cfg_m[8:6];
        return {cfg_m[ravg_pkg::RES_BOOST_BIT], acc[17:0]};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] expv);
        comparisons++;
        if (seen !== expv) begin
            n_fail++;
            $display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, expv);
        end
    endtask

    task automatic complete_run();
        $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_sys);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys);
        rd <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic set_cfg(input logic [9:0] c);
        if (c[1] !== cfg_m[1]) fill = 1'b1;
        cfg_m = c;
        wr_reg(ravg_pkg::REG_CFG, {22'h0, c});
    endtask

    task automatic wait_valid(output logic seen);
        seen = 1'b0;
        for (int i = 0; i < 60 && !seen; i++) begin
            @(posedge clk_sys);
            #1 seen = link.res_valid;
        end
    endtask

    task automatic convert();
        logic [31:0] r;
        logic        seen;
        r = xs();
        @(posedge clk_sys);
        sample_a <= r[15:0];
        sample_b <= r[31:16];
        for (int i = 7; i > 0; i--) begin
            ha[i] = fill ? r[15:0] : ha[i-1];
            hb[i] = fill ? r[31:16] : hb[i-1];
        end
        ha[0] = r[15:0];
        hb[0] = r[31:16];
        fill = 1'b0;
        wr_reg(ravg_pkg::REG_CTRL, 32'h1);
        wait_valid(seen);
        ea = exp_out(ha);
        eb = exp_out(hb);
        check({31'h0, seen}, 32'h1);
        check({13'h0, link.res_wide, link.res_a}, {13'h0, ea});
        check({13'h0, link.res_wide, link.res_b}, {13'h0, eb});
        check({21'h0, avg_active, config_view}, {21'h0, avg_on(cfg_m), cfg_m});
    endtask

    initial begin
        logic [31:0] d;
        logic        seen;
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        rd_reg(ravg_pkg::REG_CFG, d);
        check(d, 32'h0);
        rd_reg(8'hFC, d);
        check(d, 32'h0);
        set_cfg(10'h2C0);
        convert();
        rd_reg(ravg_pkg::REG_STATUS, d);
        check({31'h0, d[ravg_pkg::ST_SETTLED_BIT]}, 32'h0);
        $display("early test done");
        repeat (ravg_pkg::SETTLE_CYCLES) @(posedge clk_sys);
        convert();
        rd_reg(ravg_pkg::REG_STATUS, d);
        check({29'h0, d[3:1]}, 32'h3);
        rd_reg(ravg_pkg::REG_RES_A, d);
        check({14'h0, d[17:0]}, {14'h0, ea[17:0]});
        rd_reg(ravg_pkg::REG_RES_B, d);
        check(d, {{14{eb[17]}}, eb[17:0]});
        rd_reg(ravg_pkg::REG_STATUS, d);
        check({31'h0, d[ravg_pkg::ST_NEW_BIT]}, 32'h0);
        $display("settle test done");
        // Every ratio code with averaging off and on, boost and reference random
        for (int k = 0; k < 64; k++) begin
            d = xs();
            if (k % 4 == 0) set_cfg({k[5], k[4:2], 3'h0, d[2:1], 1'b0});
            convert();
        end
        $display("sweep test done");
        set_cfg(10'h2C4);
        convert();
        rd_reg(ravg_pkg::REG_STATUS, d);
        check({31'h0, d[ravg_pkg::ST_WIDE_BIT]}, 32'h1);
        wr_reg(ravg_pkg::REG_CTRL, 32'h2);
        fill = 1'b1;
        rd_reg(ravg_pkg::REG_CFG, d);
        check(d, {22'h0, cfg_m});
        convert();
        // Soft reset in mid-conversion must swallow the result
        wr_reg(ravg_pkg::REG_CTRL, 32'h1);
        repeat (3) @(posedge clk_sys);
        rd_reg(ravg_pkg::REG_STATUS, d);
        check({31'h0, d[ravg_pkg::ST_BUSY_BIT]}, 32'h1);
        wr_reg(ravg_pkg::REG_CTRL, 32'h2);
        fill = 1'b1;
        wait_valid(seen);
        check({31'h0, seen}, 32'h0);
        convert();
        wr_reg(ravg_pkg::REG_CTRL, 32'h4);
        cfg_m = 10'h000;
        fill = 1'b1;
        rd_reg(ravg_pkg::REG_CFG, d);
        check(d, 32'h0);
        convert();
        $display("reset test done");
        complete_run();
    end

    initial begin
        #(8 * 20000);
        n_fail++;
        complete_run();
    end
endmodule
`default_nettype wire
